/* File: hw/dsadc_top.sv */
// dual-slope converter control: bus registers, conversion sequencer and analog unit drive
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "dsadc_regs.svh"
module dsadc_top #(
   parameter int unsigned INT60_CYC = `DSADC_T60_CYC,
   parameter int unsigned INT50_CYC = `DSADC_T50_CYC,
   parameter int unsigned RESTART_CYC = `DSADC_RESTART_CYC,
   parameter logic [7:0] ID_TWO_WIRE = 8'hA5,  // arbitrary value
   parameter logic [7:0] ID_THREE_WIRE = 8'h5A // arbitrary value
) (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic POLARITY_PULSE,
   input wire logic FINISH_PULSE,
   output logic PHASE_ADVANCE_PULSE,
   output logic ADC_RESET_PULSE,
   output logic [3:0] MUX_SEL,
   output logic MUX_EN,
   output logic RANGE_SEL
);
   localparam int CW = 18;
   localparam int unsigned GAP_CYC = `DSADC_GAP_CYC;
   localparam logic [CW-1:0] FULL_CNT = CW'(1 << `DSADC_MAG_W);

   // ======================================================================================
   // bus front end
   logic wr_en;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;

   dsadc_ahb u_ahb (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .hsel(HSEL),
      .haddr(HADDR),
      .htrans(HTRANS),
      .hwrite(HWRITE),
      .hwdata(HWDATA),
      .hready(HREADY),
      .rdata(rdata),
      .wr_en(wr_en),
      .addr(addr),
      .wdata(wdata),
      .hrdata(HRDATA),
      .hreadyout(HREADYOUT),
      .hresp(HRESP)
   );

   // ======================================================================================
   // state declarations
   logic [2:0] ctrl_ff;
   logic [15:0] range_map_ff;
   logic [3:0] last_chan_ff;
   logic [3:0] pend_chan_ff;
   logic pend_ff;
   logic [3:0] act_chan_ff;
   logic [3:0] conv_chan_ff;
   logic [15:0] data_ff;
   logic done_ff;
   logic err_ff;
   logic ovrun_ff;
   logic active_ff;
   logic sign_ff;
   logic [CW-1:0] cnt_ff;
   dsadc_pkg::dsadc_state_type state_ff;
   logic mux_en_ff;
   logic [3:0] mux_sel_ff;
   logic range_sel_ff;

   logic line_50hz;
   logic three_wire;
   logic inputs_off;
   logic [CW-1:0] int_last;
   logic chan_wr;
   logic stat_wr;
   logic chan_bad;
   logic start;
   logic store;
   logic overrange;
   logic adv_req;
   logic rst_req;

   assign line_50hz = ctrl_ff[`DSADC_CTRL_50HZ];
   assign three_wire = ctrl_ff[`DSADC_CTRL_3WIRE];
   assign inputs_off = ctrl_ff[`DSADC_CTRL_OFF];
   assign chan_wr = wr_en & (addr == `DSADC_CHAN_OFS);
   assign stat_wr = wr_en & (addr == `DSADC_STAT_OFS);

   // integration length picked by the line frequency setting
   assign int_last = line_50hz ? CW'(INT50_CYC - 1) : CW'(INT60_CYC - 1);

   // three-wire mode leaves only eight inputs, so bit 3 of the channel is illegal
   assign chan_bad = three_wire & wdata[3];

   // ======================================================================================
   // configuration registers
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         ctrl_ff <= `DSADC_CTRL_RST;
         range_map_ff <= `DSADC_RANGE_RST;
      end else if (wr_en) begin
         if (addr == `DSADC_CTRL_OFS) begin
            ctrl_ff <= wdata[2:0];
         end
         if (addr == `DSADC_RANGE_OFS) begin
            range_map_ff <= wdata[15:0];
         end
      end
   end

   // ======================================================================================
   // channel request: one channel can wait while another converts
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         pend_ff <= 1'b0;
         pend_chan_ff <= 4'h0;
         last_chan_ff <= 4'h0;
      end else begin
         if (chan_wr && !chan_bad && !pend_ff) begin
            pend_ff <= 1'b1;
            pend_chan_ff <= wdata[3:0];
            last_chan_ff <= wdata[3:0];
         end else if (start) begin
            pend_ff <= 1'b0;
         end
      end
   end

   // ======================================================================================
   // sequencer transitions
   assign start = (state_ff == dsadc_pkg::S_IDLE) & pend_ff;
   assign overrange = (cnt_ff == FULL_CNT - CW'(1));
   assign store = (state_ff == dsadc_pkg::S_INT_REF) & (FINISH_PULSE | overrange);

   // restart pulse opens each cycle; advances open input, close input and start reference
   assign rst_req = start;
   always_comb begin
      adv_req = 1'b0;
      unique case (state_ff)
         dsadc_pkg::S_RESTART: adv_req = (cnt_ff == CW'(RESTART_CYC - 1));
         dsadc_pkg::S_INT_IN: adv_req = (cnt_ff == int_last);
         dsadc_pkg::S_GAP: adv_req = (cnt_ff == CW'(GAP_CYC - 1));
         dsadc_pkg::S_IDLE, dsadc_pkg::S_INT_REF: adv_req = 1'b0;
      endcase
   end

   // ======================================================================================
   // conversion sequencer and counter
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         state_ff <= dsadc_pkg::S_IDLE;
         cnt_ff <= '0;
         act_chan_ff <= 4'h0;
      end else begin
         unique case (state_ff)
            dsadc_pkg::S_IDLE: begin
               // counter holds the last result count while idle
               if (start) begin
                  state_ff <= dsadc_pkg::S_RESTART;
                  cnt_ff <= '0;
                  act_chan_ff <= pend_chan_ff;
               end
            end
            dsadc_pkg::S_RESTART: begin
               if (adv_req) begin
                  state_ff <= dsadc_pkg::S_INT_IN;
                  cnt_ff <= '0;
               end else begin
                  cnt_ff <= cnt_ff + CW'(1);
               end
            end
            dsadc_pkg::S_INT_IN: begin
               // fixed count, input stays on the integrator throughout
               if (adv_req) begin
                  state_ff <= dsadc_pkg::S_GAP;
                  cnt_ff <= '0;
               end else begin
                  cnt_ff <= cnt_ff + CW'(1);
               end
            end
            dsadc_pkg::S_GAP: begin
               if (adv_req) begin
                  state_ff <= dsadc_pkg::S_INT_REF;
                  cnt_ff <= '0;
               end else begin
                  cnt_ff <= cnt_ff + CW'(1);
               end
            end
            dsadc_pkg::S_INT_REF: begin
               // comparator trip freezes the count; full scale ends as overrange
               if (store) begin
                  state_ff <= dsadc_pkg::S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff + CW'(1);
               end
            end
         endcase
      end
   end

   // ======================================================================================
   // polarity capture: a pulse near the end of input integration marks a negative input
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         sign_ff <= 1'b0;
      end else if (start) begin
         sign_ff <= 1'b0;
      end else if (POLARITY_PULSE && (state_ff == dsadc_pkg::S_INT_IN ||
                                      state_ff == dsadc_pkg::S_GAP)) begin
         sign_ff <= 1'b1;
      end
   end

   // ======================================================================================
   // result transfer; while done is still set the held result is kept and the new one lost
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         data_ff <= 16'h0000;
         conv_chan_ff <= 4'h0;
      end else if (store && !done_ff) begin
         data_ff[`DSADC_MAG_W-1:0] <= cnt_ff[`DSADC_MAG_W-1:0];
         data_ff[`DSADC_RES_SIGN] <= sign_ff;
         data_ff[`DSADC_RES_OVR] <= overrange & ~FINISH_PULSE;
         conv_chan_ff <= act_chan_ff;
      end
   end

   // ======================================================================================
   // status flags: write one to clear, a set in the same cycle wins
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         ovrun_ff <= 1'b0;
      end else begin
         done_ff <= (store & ~done_ff) |
                    (done_ff & ~(stat_wr & wdata[`DSADC_ST_DONE]));
         err_ff <= (chan_wr & (chan_bad | pend_ff)) |
                   (err_ff & ~(stat_wr & wdata[`DSADC_ST_ERR]));
         ovrun_ff <= (store & done_ff) |
                     (ovrun_ff & ~(stat_wr & wdata[`DSADC_ST_OVRUN]));
      end
   end

   // active from any accepted channel write until the queue drains
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         active_ff <= 1'b0;
      end else if (chan_wr && !chan_bad && !pend_ff) begin
         active_ff <= 1'b1;
      end else if (state_ff == dsadc_pkg::S_IDLE && !pend_ff) begin
         active_ff <= 1'b0;
      end
   end

   // ======================================================================================
   // analog unit drive: relays, range and isolated control pulses
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         mux_en_ff <= 1'b0;
         mux_sel_ff <= 4'h0;
         range_sel_ff <= 1'b0;
      end else begin
         // disable opens every relay regardless of the sequencer
         mux_en_ff <= ~inputs_off & (state_ff != dsadc_pkg::S_IDLE);
         mux_sel_ff <= act_chan_ff;
         range_sel_ff <= range_map_ff[act_chan_ff];
      end
   end

   dsadc_pulse #(
      .WIDTH(`DSADC_PULSE_CYC)
   ) u_adv (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .trig(adv_req),
      .pulse(PHASE_ADVANCE_PULSE)
   );

   dsadc_pulse #(
      .WIDTH(`DSADC_PULSE_CYC)
   ) u_rst (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .trig(rst_req),
      .pulse(ADC_RESET_PULSE)
   );

   assign MUX_EN = mux_en_ff;
   assign MUX_SEL = mux_sel_ff;
   assign RANGE_SEL = range_sel_ff;

   // ======================================================================================
   // read multiplexer; unmapped addresses read zero
   always_comb begin
      rdata = 32'h00000000;
      unique case (addr)
         `DSADC_CTRL_OFS: rdata[2:0] = ctrl_ff;
         `DSADC_RANGE_OFS: rdata[15:0] = range_map_ff;
         `DSADC_CHAN_OFS: rdata[7:0] = {conv_chan_ff, last_chan_ff};
         `DSADC_STAT_OFS: rdata[4:0] = {active_ff, pend_ff, ovrun_ff, err_ff, done_ff};
         `DSADC_DLO_OFS: rdata[7:0] = data_ff[7:0];
         `DSADC_DHI_OFS: rdata[7:0] = data_ff[15:8];
         `DSADC_ID_OFS: rdata[7:0] = three_wire ? ID_THREE_WIRE : ID_TWO_WIRE;
         default: rdata = 32'h00000000;
      endcase
   end

   // HSIZE is accepted as word only; narrower sizes act as whole words
   logic unused_size;
   assign unused_size = ^HSIZE;
endmodule // dsadc_top

/* File: hw/dsadc_regs.svh */
// register offsets, field positions, reset values and timing counts of the converter control
// ==========================================================================================
// Operation
// - input integration runs fixed clock count
// - switch to reference and clear counter together
// - comparator trip stops counter, count is result
// - setting picks 16-2/3 ms or 20 ms
// - selects one of 16 or 8 inputs
// - result: 14 magnitude, sign, overrange bits
// - analog unit returns polarity and finish pulses
// - phases sequenced by advance and reset pulses
// - each channel uses one of two ranges
// - identification word readable; all inputs disable
// - bits 0-13 magnitude, 14 sign, 15 overrange
// - restart pulse, 2 ms later clear and advance
`ifndef DSADC_REGS_SVH
`define DSADC_REGS_SVH

// ==========================================================================================
// register byte offsets
`define DSADC_CTRL_OFS 8'h00
`define DSADC_RANGE_OFS 8'h04
`define DSADC_CHAN_OFS 8'h08
`define DSADC_STAT_OFS 8'h0C
`define DSADC_DLO_OFS 8'h10
`define DSADC_DHI_OFS 8'h14
`define DSADC_ID_OFS 8'h18

// ==========================================================================================
// field positions
`define DSADC_CTRL_50HZ 0
`define DSADC_CTRL_3WIRE 1
`define DSADC_CTRL_OFF 2
`define DSADC_ST_DONE 0
`define DSADC_ST_ERR 1
`define DSADC_ST_OVRUN 2
`define DSADC_ST_BUSY 3
`define DSADC_ST_ACTIVE 4
`define DSADC_RES_SIGN 14
`define DSADC_RES_OVR 15
`define DSADC_MAG_W 14
`define DSADC_CTRL_RST 3'h0
`define DSADC_RANGE_RST 16'h0000

// ==========================================================================================
// timing: figures in ns, counts derived at 100 ns clock
`define DSADC_CLK_NS 100
`define DSADC_T60_NS 16666667
`define DSADC_T50_NS 20000000
`define DSADC_RESTART_NS 2000000
`define DSADC_GAP_NS 4000
`define DSADC_PULSE_NS 1000
`define DSADC_T60_CYC (`DSADC_T60_NS / `DSADC_CLK_NS)
`define DSADC_T50_CYC (`DSADC_T50_NS / `DSADC_CLK_NS)
`define DSADC_RESTART_CYC ((`DSADC_RESTART_NS + `DSADC_CLK_NS - 1) / `DSADC_CLK_NS)
`define DSADC_GAP_CYC ((`DSADC_GAP_NS + `DSADC_CLK_NS - 1) / `DSADC_CLK_NS)
`define DSADC_PULSE_CYC ((`DSADC_PULSE_NS + `DSADC_CLK_NS - 1) / `DSADC_CLK_NS)

`endif

/* File: hw/dsadc_pkg.sv */
// types shared by the converter control design
package dsadc_pkg;
   // ======================================================================================
   // conversion sequencer states
   typedef enum logic [2:0] {
      S_IDLE,
      S_RESTART,
      S_INT_IN,
      S_GAP,
      S_INT_REF
   } dsadc_state_type;
endpackage

/* File: hw/dsadc_ahb.sv */
// AHB-Lite slave front end: turns bus transfers into register strobes
`timescale 1ns/1ps
module dsadc_ahb (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] rdata,
   output logic wr_en,
   output logic [7:0] addr,
   output logic [31:0] wdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   // ======================================================================================
   // address phase capture
   logic wph_ff;
   logic rph_ff;
   logic [7:0] addr_ff;
   logic hready_ff;
   logic [31:0] hrdata_ff;
   logic hresp_ff;
   logic accept;

   assign accept = hsel & htrans[1] & hready;

   // reads take one wait state so the read data comes straight from a flop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wph_ff <= 1'b0;
         rph_ff <= 1'b0;
         addr_ff <= 8'h00;
         hready_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end else begin
         wph_ff <= accept & hwrite;
         rph_ff <= accept & ~hwrite;
         hready_ff <= ~(accept & ~hwrite);
         hresp_ff <= 1'b0; // always OKAY
         if (accept) begin
            addr_ff <= haddr[7:0];
         end
      end
   end

   // read data sampled in the wait cycle, after any earlier write has landed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata_ff <= 32'h00000000;
      end else if (rph_ff) begin
         hrdata_ff <= rdata;
      end
   end

   assign wr_en = wph_ff;
   assign addr = addr_ff;
   assign wdata = hwdata;
   assign hrdata = hrdata_ff;
   assign hreadyout = hready_ff;
   assign hresp = hresp_ff;
endmodule // dsadc_ahb

/* File: hw/dsadc_pulse.sv */
// fixed-width pulse stretcher for the isolated control lines
`timescale 1ns/1ps
module dsadc_pulse #(
   parameter int unsigned WIDTH = 10
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trig,
   output logic pulse
);
   // ======================================================================================
   // width counter; a retrigger restarts the width
   logic [7:0] cnt_ff;
   logic out_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_ff <= 8'h00;
         out_ff <= 1'b0;
      end else begin
         if (trig) begin
            cnt_ff <= 8'(WIDTH);
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
         out_ff <= trig | (cnt_ff > 8'h01);
      end
   end

   assign pulse = out_ff;
endmodule // dsadc_pulse

/* File: verif/dsadc_analog_model.sv */
// behavioural model of the isolated integrator, comparator and relay unit
`timescale 1ns/1ps
module dsadc_analog_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic adv,
   input wire logic areset,
   input wire logic neg,
   input wire logic [15:0] ref_cyc,
   output logic pol,
   output logic fin
);
   logic adv_q;
   logic run_ff;
   logic [1:0] phase_ff;
   logic [15:0] cnt_ff;
   logic [3:0] pol_ff;
   logic [3:0] fin_ff;
   // pulses idle low between frames, as the transformer lines do
   assign pol = pol_ff != 4'h0;
   assign fin = fin_ff != 4'h0;
   // ===================================
   // advance pulses step the phase, the reset pulse starts a new cycle
   always_ff @(posedge clk) begin
      adv_q <= adv;
      if (!rst_n || areset) begin
         phase_ff <= 2'h0;
      end else if (adv && !adv_q) begin
         phase_ff <= phase_ff + 2'h1;
      end
   end
   // a negative input answers the end of input integration with polarity
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pol_ff <= 4'h0;
      end else if (adv && !adv_q && phase_ff == 2'h1 && neg) begin
         pol_ff <= 4'hA;
      end else if (pol_ff != 4'h0) begin
         pol_ff <= pol_ff - 4'h1;
      end
   end
   // comparator trips ref_cyc cycles into reference; zero never trips
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_ff <= 1'b0;
         cnt_ff <= 16'h0000;
         fin_ff <= 4'h0;
      end else if (adv && !adv_q && phase_ff == 2'h2) begin
         run_ff <= ref_cyc != 16'h0000;
         cnt_ff <= ref_cyc;
      end else if (run_ff) begin
         cnt_ff <= cnt_ff - 16'h0001;
         run_ff <= cnt_ff != 16'h0001;
         fin_ff <= (cnt_ff == 16'h0001) ? 4'hA : 4'h0;
      end else if (fin_ff != 4'h0) begin
         fin_ff <= fin_ff - 4'h1;
      end
   end
endmodule // dsadc_analog_model

/* File: verif/dsadc_properties.sv */
// concurrent checks on the converter control top-level ports
`timescale 1ns/1ps
`include "dsadc_regs.svh"
module dsadc_properties #(
   parameter int unsigned INT60_CYC = `DSADC_T60_CYC,
   parameter int unsigned INT50_CYC = `DSADC_T50_CYC,
   parameter int unsigned RESTART_CYC = `DSADC_RESTART_CYC
) (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic PHASE_ADVANCE_PULSE,
   input wire logic ADC_RESET_PULSE
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!NRST);
   logic adv_q, rst_q;
   logic [1:0] idx;
   logic [31:0] since, alen, rlen;
   wire logic adv_up = PHASE_ADVANCE_PULSE && !adv_q;
   wire logic rst_up = ADC_RESET_PULSE && !rst_q;
   // slack of two cycles: the count edge alignment against the pulse is not pinned down
   function automatic logic near(input logic [31:0] v, input int unsigned c);
      return (v + 32'h2 >= c) && (v <= c + 2);
   endfunction
   // ===================================
   // pulse history: which advance, spacing since last rise, width so far
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         adv_q <= 1'b0;
         rst_q <= 1'b0;
         idx <= 2'h0;
         since <= 32'h0;
         alen <= 32'h0;
         rlen <= 32'h0;
      end else begin
         adv_q <= PHASE_ADVANCE_PULSE;
         rst_q <= ADC_RESET_PULSE;
         idx <= rst_up ? 2'h0 : idx + {1'b0, adv_up};
         since <= (adv_up || rst_up) ? 32'h1 : since + 32'h1;
         alen <= PHASE_ADVANCE_PULSE ? alen + 32'h1 : 32'h0;
         rlen <= ADC_RESET_PULSE ? rlen + 32'h1 : 32'h0;
      end
   end
   // ===================================
   // bus answers
   sequence seq_rd;
      HSEL && HTRANS[1] && HREADY && !HWRITE;
   endsequence
   sequence seq_wait;
      !HREADYOUT ##1 HREADYOUT;
   endsequence
   AST_READ_WAIT: assert property (seq_rd |=> seq_wait)
      else $error("read not answered after one wait state");
   AST_WRITE_NOWAIT: assert property (HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT)
      else $error("write was stalled");
   AST_OKAY: assert property (HRESP == 1'b0)
      else $error("response not okay");
   AST_RDATA_HOLD: assert property ($changed(HRDATA) |-> $rose(HREADYOUT))
      else $error("read data moved outside a read answer");
   // ===================================
   // sequencing of the analog unit
   AST_ADV_WIDTH: assert property (!PHASE_ADVANCE_PULSE && adv_q |-> alen == `DSADC_PULSE_CYC)
      else $error("advance pulse width wrong");
   AST_RST_WIDTH: assert property (!ADC_RESET_PULSE && rst_q |-> rlen == `DSADC_PULSE_CYC)
      else $error("reset pulse width wrong");
   AST_RESTART: assert property (adv_up && idx == 2'h0 |-> near(since, RESTART_CYC))
      else $error("restart delay wrong");
   AST_INTEG: assert property (adv_up && idx == 2'h1 |->
      near(since, INT60_CYC) || near(since, INT50_CYC))
      else $error("input integration length wrong");
   AST_GAP: assert property (adv_up && idx == 2'h2 |-> near(since, `DSADC_GAP_CYC))
      else $error("gap before reference wrong");
   AST_ADV_COUNT: assert property (adv_up |-> idx != 2'h3)
      else $error("more than three advances in one cycle");
endmodule // dsadc_properties

bind dsadc_top dsadc_properties #(.INT60_CYC(INT60_CYC), .INT50_CYC(INT50_CYC),
   .RESTART_CYC(RESTART_CYC)) u_props (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PHASE_ADVANCE_PULSE(PHASE_ADVANCE_PULSE),
   .ADC_RESET_PULSE(ADC_RESET_PULSE));

/* File: verif/dual_slope_adc_control_tb_top.sv */
// self-checking bench: bus tasks, conversion sequences and result checks
`timescale 1ns/1ps
`include "dsadc_regs.svh"
module dual_slope_adc_control_tb_top;
   localparam int unsigned I60 = 50;
   localparam int unsigned I50 = 60;
   localparam logic [7:0] ID2 = 8'h3C; // arbitrary value
   localparam logic [7:0] ID3 = 8'hC3; // arbitrary value
   localparam logic [15:0] RNG = 16'h8081;
   localparam logic [2:0] CT [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   localparam logic [3:0] CH [4] = '{4'h3, 4'hF, 4'h7, 4'h0};
   localparam logic [15:0] RC [4] = '{16'h0064, 16'h012C, 16'h0000, 16'h0096};
   logic clk, nrst, hsel, hwrite, neg, hready, hresp, pol, fin, adv, arst, mux_en, rsel;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] mux_sel;
   logic [15:0] ref_cyc;
   logic [31:0] haddr, hwdata, hrdata;
   int fail_count = 0;
   int n_compared = 0;
   // the slave's own ready closes the loop, as on a one-slave bus
   dsadc_top #(.INT60_CYC(I60), .INT50_CYC(I50), .RESTART_CYC(20), .ID_TWO_WIRE(ID2),
      .ID_THREE_WIRE(ID3)) dut (.SYS_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .POLARITY_PULSE(pol),
      .FINISH_PULSE(fin), .PHASE_ADVANCE_PULSE(adv), .ADC_RESET_PULSE(arst),
      .MUX_SEL(mux_sel), .MUX_EN(mux_en), .RANGE_SEL(rsel));
   dsadc_analog_model u_ana (.clk(clk), .rst_n(nrst), .adv(adv), .areset(arst), .neg(neg),
      .ref_cyc(ref_cyc), .pol(pol), .fin(fin));
   // ===================================
   // comparison, bus and wait tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic take();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1 && n < 9) begin
         @(posedge clk);
         n++;
      end
      if (n == 9) chk(32'h0, 32'h1);
   endtask
   // address phase, then data phase; read data taken at the closing edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      take();
      htrans <= 2'h0;
      hwdata <= d;
      take();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, e);
   endtask
   // time of the next advance pulse, then let it end
   task automatic wadv(output time t);
      int n;
      n = 0;
      while (adv !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 400), 32'h1);
      t = $time;
      while (adv === 1'b1) @(posedge clk);
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ===================================
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      logic [15:0] res, k;
      logic [31:0] q;
      time t0, t1, t2;
      time ti [2];
      int n;
      {nrst, hsel, hwrite, neg, htrans, hsize} = {4'h4, 2'h0, 3'h2};
      {haddr, hwdata, ref_cyc} = '0;
      k = 16'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(`DSADC_CTRL_OFS, 32'h0);
      rd(`DSADC_RANGE_OFS, 32'h0);
      rd(`DSADC_ID_OFS, {24'h0, ID2});
      rd(8'h20, 32'h0);
      wr(`DSADC_RANGE_OFS, {16'h0, RNG});
      rd(`DSADC_RANGE_OFS, {16'h0, RNG});
      // 60 Hz, 50 Hz, three-wire overrange, inputs off; mixed signs
      for (int i = 0; i < 4; i++) begin
         neg <= i[0];
         ref_cyc <= RC[i];
         wr(`DSADC_CTRL_OFS, {29'h0, CT[i]});
         wr(`DSADC_CHAN_OFS, {28'h0, CH[i]});
         wadv(t0);
         chk(32'(mux_en), 32'(!CT[i][2]));
         chk(32'(mux_sel), 32'(CH[i]));
         chk(32'(rsel), 32'(RNG[CH[i]]));
         wadv(t1);
         if (i < 2) ti[i] = t1 - t0;
         wadv(t2);
         q = 32'h0;
         n = 0;
         while (q[0] !== 1'b1 && n < 6000) begin
            bus(`DSADC_STAT_OFS, 1'b0, 32'h0, q);
            n++;
         end
         chk(32'(q[0]), 32'h1);
         bus(`DSADC_DLO_OFS, 1'b0, 32'h0, q);
         res[7:0] = q[7:0];
         bus(`DSADC_DHI_OFS, 1'b0, 32'h0, q);
         res[15:8] = q[7:0];
         chk(32'(res[14]), 32'(i[0]));
         chk(32'(res[15]), 32'(RC[i] == 16'h0));
         // the count offset is fixed, so equal reference steps give equal offsets
         if (i == 0) k = {2'h0, res[13:0]} - RC[0];
         else if (RC[i] != 16'h0) chk(32'({2'h0, res[13:0]} - RC[i]), 32'(k));
         else chk(32'(res[13:0]), 32'h3FFF);
         // converted and last programmed channel both name this conversion
         rd(`DSADC_CHAN_OFS, {24'h0, CH[i], CH[i]});
         wr(`DSADC_STAT_OFS, 32'h7);
         bus(`DSADC_STAT_OFS, 1'b0, 32'h0, q);
         chk(32'(q[0]), 32'h0);
      end
      chk(32'(ti[1] - ti[0]), 32'((I50 - I60) * 100));
      wr(`DSADC_CTRL_OFS, 32'h2);
      rd(`DSADC_ID_OFS, {24'h0, ID3});
      // channel 8 is beyond three-wire range: flagged and never started
      wr(`DSADC_CHAN_OFS, 32'h8);
      bus(`DSADC_STAT_OFS, 1'b0, 32'h0, q);
      chk(32'(q[1]), 32'h1);
      chk(32'(arst), 32'h0);
      // one converts, one waits (busy), a third is refused and leaves last channel alone
      wr(`DSADC_STAT_OFS, 32'h7);
      wr(`DSADC_CHAN_OFS, 32'h1);
      wr(`DSADC_CHAN_OFS, 32'h2);
      wr(`DSADC_CHAN_OFS, 32'h3);
      rd(`DSADC_STAT_OFS, 32'h1A);
      rd(`DSADC_CHAN_OFS, 32'h2);
      conclude();
   end
endmodule // dual_slope_adc_control_tb_top
